// ===== common/asf_pkg.sv
// Purpose: shared constants and state types for the alarm status flag block
// Assumes: 100 MHz clock, APB word registers at byte address = index * 4
// Notes:   limits reset to the widest range so no pv alert fires before setup
package asf_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int NCH = 4;
  localparam int DW  = 16;

  // register indexes, byte address is index times four
  localparam logic [11:0] IDX_WARN      = 12'h002;
  localparam logic [11:0] IDX_DEF0      = 12'h004;
  localparam logic [11:0] IDX_DEF3      = 12'h007;
  localparam logic [11:0] IDX_FLAGS     = 12'h010;
  localparam logic [11:0] IDX_CTRL      = 12'h011;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'h012;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'h013;
  localparam logic [11:0] IDX_LIM0      = 12'h020;
  localparam logic [11:0] IDX_LIM_LAST  = 12'h02F;
  localparam logic [11:0] IDX_HIST0     = 12'hA00;
  localparam logic [11:0] IDX_HIST_LAST = 12'hA0F;

  // history entry word offsets
  localparam logic [3:0] HIST_CODE = 4'h0;
  localparam logic [3:0] HIST_ADDR = 4'h6;
  localparam logic [3:0] HIST_PV   = 4'h7;
  localparam logic [3:0] HIST_MV   = 4'h8;
  localparam logic [3:0] HIST_SV   = 4'h9;

  // alert index inside a channel, definition bit is index plus DEF_SHIFT
  localparam int ALR_PV_HI   = 0;
  localparam int ALR_PV_LO   = 1;
  localparam int ALR_RATE_HI = 2;
  localparam int ALR_RATE_LO = 3;
  localparam int DEF_SHIFT   = 2;

  // limit kind inside a channel limit group
  localparam int LIM_PV_HI   = 0;
  localparam int LIM_PV_LO   = 1;
  localparam int LIM_RATE_HI = 2;
  localparam int LIM_RATE_LO = 3;

  // warning code per alert kind, channel number goes in bits 7:4
  localparam logic [3:0][15:0] CODE_BASE =
    {16'h0D0A, 16'h0C0A, 16'h0B0A, 16'h0A0A};

  localparam int CTRL_TEST_BIT = 0;
  localparam int IRQ_W         = 5;
  localparam int IRQ_TEST_BIT  = 4;

  localparam logic [15:0] PV_HI_RST   = 16'h7FFF;
  localparam logic [15:0] PV_LO_RST   = 16'h8000;
  localparam logic [15:0] RATE_HI_RST = 16'h7FFF;
  localparam logic [15:0] RATE_LO_RST = 16'h8000;
  localparam logic [3:0][3:0][15:0] LIM_RST =
    {4{RATE_LO_RST, RATE_HI_RST, PV_LO_RST, PV_HI_RST}};

  // unit test length and mode indicator half period
  localparam int unsigned TEST_TIME_US  = 1000;
  localparam int unsigned TEST_CYCLES   =
    TEST_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_CYCLES  =
    FLASH_HALF_MS * (CLK_FREQ_HZ / 1000);

  typedef struct packed {
    logic signed [15:0] prev_pv;
    logic               primed;
    logic [3:0]         alert;
  } asf_chan_st_t;

  typedef struct packed {
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [3:0][3:0][15:0]   lim;
    logic [3:0][3:0]         al;
    logic [15:0]             code;
    logic                    code_vld;
    logic [1:0]              src_ch;
    logic [1:0]              src_bit;
    logic [15:0][15:0]       hist;
    logic [IRQ_W-1:0]        irq_stat;
    logic [IRQ_W-1:0]        irq_mask;
    logic                    run;
    logic                    done;
    logic                    flash;
    logic [31:0]             test_cnt;
    logic [31:0]             flash_cnt;
  } asf_top_st_t;
endpackage : asf_pkg

// ===== common/asf_chan_if.sv
// Purpose: carries one channel's sample, limits and alert bits
// Assumes: all signals on the block clock
// Notes:   alert order is pv high, pv low, rate high, rate low
`timescale 1ns/10ps
interface asf_chan_if;
  logic                     sample;
  logic signed [15:0]       pv;
  logic signed [15:0]       pv_hi;
  logic signed [15:0]       pv_lo;
  logic signed [15:0]       rate_hi;
  logic signed [15:0]       rate_lo;
  logic [3:0]               alert;
  modport chk (input sample, pv, pv_hi, pv_lo, rate_hi, rate_lo,
               output alert);
  modport ctl (output sample, pv, pv_hi, pv_lo, rate_hi, rate_lo,
               input alert);
endinterface : asf_chan_if

// ===== design/asf_chan_check.sv
// Purpose: limit checker for one channel, re-evaluated on every sample
// Assumes: sample is a one-cycle pulse on the block clock
// Notes:   rate alerts stay off until a second sample gives a difference
`timescale 1ns/10ps
module asf_chan_check (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // channel link
  asf_chan_if.chk  ch
);
  asf_pkg::asf_chan_st_t st;
  asf_pkg::asf_chan_st_t next_st;
  logic signed [16:0]    delta;

  always_comb begin
    next_st = st;
    delta   = 17'(ch.pv) - 17'(st.prev_pv);
    if (ch.sample) begin
      next_st.prev_pv = ch.pv;
      next_st.primed  = 1'b1;
      next_st.alert[asf_pkg::ALR_PV_HI] = ch.pv > ch.pv_hi;
      next_st.alert[asf_pkg::ALR_PV_LO] = ch.pv < ch.pv_lo;
      next_st.alert[asf_pkg::ALR_RATE_HI] =
        st.primed && (delta > 17'(ch.rate_hi));
      next_st.alert[asf_pkg::ALR_RATE_LO] =
        st.primed && (delta < 17'(ch.rate_lo));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ch.alert = st.alert;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pv_upper_a: assert property (
    ch.sample && (ch.pv > ch.pv_hi) |=> ch.alert[asf_pkg::ALR_PV_HI])
    else $error("pv upper alert missing");
  pv_lower_a: assert property (
    ch.sample && (ch.pv < ch.pv_lo) |=> ch.alert[asf_pkg::ALR_PV_LO])
    else $error("pv lower alert missing");
  rate_upper_a: assert property (
    ch.sample && st.primed && (delta > 17'(ch.rate_hi))
    |=> ch.alert[asf_pkg::ALR_RATE_HI])
    else $error("rate upper alert missing");
  rate_lower_a: assert property (
    ch.sample && st.primed && (delta < 17'(ch.rate_lo))
    |=> ch.alert[asf_pkg::ALR_RATE_LO])
    else $error("rate lower alert missing");
  in_range_a: assert property (
    ch.sample && (ch.pv <= ch.pv_hi) && (ch.pv >= ch.pv_lo)
    |=> !ch.alert[asf_pkg::ALR_PV_HI] && !ch.alert[asf_pkg::ALR_PV_LO])
    else $error("pv alert not cleared in range");
endmodule : asf_chan_check

// ===== design/asf_alarm_status.sv
// Purpose: four-channel alarm status, warning code, history, indicators
// Assumes: process, manipulated and set values come from same-clock logic
// Notes:   APB slave with zero wait states, read data captured at setup
//
// Function
// - pv above upper limit lights alarm, sets flag and bit 2.
// - pv below lower limit lights alarm, sets flag and bit 3.
// - rate above upper limit lights alarm, sets flag and bit 4.
// - rate below lower limit lights alarm, sets flag and bit 5.
// - one alert flag per channel on four consecutive bits.
// - back in range clears definition bit and channel flag by itself.
// - latest warning code clears itself once its cause is back in range.
// - each alert stores address, pv, mv and sv in history details.
// - first history entry is sixteen words with details at fixed offsets.
// - mode indicator flashes in unit test only when TEST_CYCLES exceeds FLASH_CYCLES; link indicator on when done.
// - with several errors only the newest code is kept.
`timescale 1ns/10ps
module asf_alarm_status #(
  parameter int unsigned TEST_CYCLES  = asf_pkg::TEST_CYCLES,
  parameter int unsigned FLASH_CYCLES = asf_pkg::FLASH_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic [15:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // channel measurements
  input  wire logic              sample_valid,
  input  wire logic [3:0][15:0]  process_value,
  input  wire logic [3:0][15:0]  manipulated_value,
  input  wire logic [3:0][15:0]  set_value,
  // remote status
  output logic [3:0]             channel_alert_flag_bits,
  output logic [3:0][15:0]       channel_alert_definition_words,
  output logic [15:0]            latest_warning_code_word,
  // indicators and interrupt
  output logic                   alarm_indicator,
  output logic                   mode_indicator,
  output logic                   link_activity_indicator,
  output logic                   irq
);
  asf_pkg::asf_top_st_t st;
  asf_pkg::asf_top_st_t next_st;
  logic [3:0][3:0]      a;
  logic [3:0][3:0]      newb;
  logic [3:0]           any_now;
  logic [11:0]          idx;
  logic                 setup;
  logic                 wr;
  logic [asf_pkg::IRQ_W-1:0] irq_set;
  logic [asf_pkg::IRQ_W-1:0] irq_clr;

  function automatic logic is_map(input logic [15:0] adr);
    logic [11:0] i;
    i = adr[13:2];
    is_map = (adr[15:14] == 2'h0) && (adr[1:0] == 2'h0) &&
             ((i == asf_pkg::IDX_WARN) ||
              (i >= asf_pkg::IDX_DEF0 && i <= asf_pkg::IDX_DEF3) ||
              (i >= asf_pkg::IDX_FLAGS && i <= asf_pkg::IDX_IRQ_MASK) ||
              (i >= asf_pkg::IDX_LIM0 && i <= asf_pkg::IDX_LIM_LAST) ||
              (i >= asf_pkg::IDX_HIST0 && i <= asf_pkg::IDX_HIST_LAST));
  endfunction : is_map

  function automatic logic [15:0] def_word(input logic [3:0] al);
    def_word = {10'h000, al, 2'h0};
  endfunction : def_word

  function automatic logic [31:0] rd_word(input logic [11:0] i,
                                          input asf_pkg::asf_top_st_t s);
    rd_word = 32'h0000_0000;
    if (i == asf_pkg::IDX_WARN) begin
      rd_word[15:0] = s.code;
    end else if (i >= asf_pkg::IDX_DEF0 && i <= asf_pkg::IDX_DEF3) begin
      rd_word[15:0] = def_word(s.al[i[1:0]]);
    end else if (i == asf_pkg::IDX_FLAGS) begin
      for (int c = 0; c < asf_pkg::NCH; c++) begin
        rd_word[c] = |s.al[c];
      end
    end else if (i == asf_pkg::IDX_CTRL) begin
      rd_word[2:0] = {s.done, s.run, s.run};
    end else if (i == asf_pkg::IDX_IRQ_STAT) begin
      rd_word[asf_pkg::IRQ_W-1:0] = s.irq_stat;
    end else if (i == asf_pkg::IDX_IRQ_MASK) begin
      rd_word[asf_pkg::IRQ_W-1:0] = s.irq_mask;
    end else if (i >= asf_pkg::IDX_LIM0 && i <= asf_pkg::IDX_LIM_LAST) begin
      rd_word[15:0] = s.lim[i[3:2]][i[1:0]];
    end else if (i >= asf_pkg::IDX_HIST0 && i <= asf_pkg::IDX_HIST_LAST) begin
      rd_word[15:0] = s.hist[i[3:0]];
    end
  endfunction : rd_word

  genvar g;
  generate
    for (g = 0; g < asf_pkg::NCH; g++) begin : g_ch
      asf_chan_if chi ();
      assign chi.sample  = sample_valid;
      assign chi.pv      = process_value[g];
      assign chi.pv_hi   = st.lim[g][asf_pkg::LIM_PV_HI];
      assign chi.pv_lo   = st.lim[g][asf_pkg::LIM_PV_LO];
      assign chi.rate_hi = st.lim[g][asf_pkg::LIM_RATE_HI];
      assign chi.rate_lo = st.lim[g][asf_pkg::LIM_RATE_LO];
      assign a[g]        = chi.alert;
      asf_chan_check u_chk (
        .clk (clk),
        .rst (rst),
        .ch  (chi.chk)
      );
    end
  endgenerate

  assign idx   = paddr[13:2];
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && is_map(paddr);

  always_comb begin
    next_st = st;
    irq_set = '0;
    irq_clr = '0;
    for (int c = 0; c < asf_pkg::NCH; c++) begin
      any_now[c] = |a[c];
      newb[c]    = a[c] & ~st.al[c];
    end
    // apb setup phase captures the answer for the access phase
    if (setup) begin
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_word(idx, st);
      next_st.pslverr = !is_map(paddr);
    end
    if (wr) begin
      if (idx == asf_pkg::IDX_CTRL) begin
        // unit test start, ignored while one runs
        if (pwdata[asf_pkg::CTRL_TEST_BIT] && !st.run) begin
          next_st.run       = 1'b1;
          next_st.done      = 1'b0;
          next_st.flash     = 1'b1;
          next_st.test_cnt  = 32'(TEST_CYCLES - 1);
          next_st.flash_cnt = 32'(FLASH_CYCLES - 1);
        end
      end else if (idx == asf_pkg::IDX_IRQ_STAT) begin
        irq_clr = pwdata[asf_pkg::IRQ_W-1:0];
      end else if (idx == asf_pkg::IDX_IRQ_MASK) begin
        next_st.irq_mask = pwdata[asf_pkg::IRQ_W-1:0];
      end else if (idx >= asf_pkg::IDX_LIM0 &&
                   idx <= asf_pkg::IDX_LIM_LAST) begin
        next_st.lim[idx[3:2]][idx[1:0]] = pwdata[15:0];
      end
    end
    if (st.run) begin
      if (st.test_cnt == 32'h0000_0000) begin
        next_st.run  = 1'b0;
        next_st.done = 1'b1;
        irq_set[asf_pkg::IRQ_TEST_BIT] = 1'b1;
      end else begin
        next_st.test_cnt = st.test_cnt - 32'h0000_0001;
      end
      if (st.flash_cnt == 32'h0000_0000) begin
        next_st.flash     = !st.flash;
        next_st.flash_cnt = 32'(FLASH_CYCLES - 1);
      end else begin
        next_st.flash_cnt = st.flash_cnt - 32'h0000_0001;
      end
    end
    // code clears once its own cause is back in range
    if (st.code_vld && !a[st.src_ch][st.src_bit]) begin
      next_st.code     = 16'h0000;
      next_st.code_vld = 1'b0;
    end
    // later alerts overwrite, highest channel and bit last
    for (int c = 0; c < asf_pkg::NCH; c++) begin
      for (int b = 0; b < 4; b++) begin
        if (newb[c][b]) begin
          next_st.code = asf_pkg::CODE_BASE[b] |
                         {8'h00, 1'b0, 3'(c + 1), 4'h0};
          next_st.code_vld = 1'b1;
          next_st.src_ch   = 2'(c);
          next_st.src_bit  = 2'(b);
          irq_set[c]       = 1'b1;
          next_st.hist[asf_pkg::HIST_CODE] = next_st.code;
          next_st.hist[asf_pkg::HIST_ADDR] = 16'(asf_pkg::IDX_DEF0) + 16'(c);
          next_st.hist[asf_pkg::HIST_PV]   = process_value[c];
          next_st.hist[asf_pkg::HIST_MV]   = manipulated_value[c];
          next_st.hist[asf_pkg::HIST_SV]   = set_value[c];
        end
      end
    end
    // set wins over a clear in the same cycle
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
    next_st.al = a;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st     <= '0;
      st.lim <= asf_pkg::LIM_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.prdata;
  assign pslverr = st.pslverr;
  // no wait states, the answer is ready at every access phase
  assign pready  = 1'b1;

  always_comb begin
    for (int c = 0; c < asf_pkg::NCH; c++) begin
      channel_alert_flag_bits[c]        = |st.al[c];
      channel_alert_definition_words[c] = def_word(st.al[c]);
    end
  end
  assign alarm_indicator          = |st.al;
  assign latest_warning_code_word = st.code;
  assign mode_indicator           = st.run ? st.flash : 1'b1;
  assign link_activity_indicator  = st.done;
  assign irq                      = |(st.irq_stat & st.irq_mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence test_start_s;
    wr && (idx == asf_pkg::IDX_CTRL) &&
    pwdata[asf_pkg::CTRL_TEST_BIT] && !st.run;
  endsequence
  sequence test_end_s;
    st.run && (st.test_cnt == 32'h0000_0000);
  endsequence

  alarm_steady_a: assert property (
    (|a) |=> alarm_indicator && $stable(alarm_indicator) ||
             $rose(alarm_indicator))
    else $error("alarm indicator not on");
  flag_track_a: assert property (
    ##1 channel_alert_flag_bits == $past(any_now))
    else $error("flag bits do not follow alerts");
  code_clear_a: assert property (
    st.code_vld && !a[st.src_ch][st.src_bit] && !(|newb)
    |=> latest_warning_code_word == 16'h0000)
    else $error("warning code not cleared");
  hist_code_a: assert property (
    (|newb) |=> st.hist[asf_pkg::HIST_CODE] == latest_warning_code_word)
    else $error("history code differs from latest code");
  newest_code_a: assert property (
    newb[3][asf_pkg::ALR_RATE_LO]
    |=> latest_warning_code_word == 16'h0D4A)
    else $error("newest code not kept");
  test_flash_a: assert property (
    test_start_s |=> st.run && !link_activity_indicator && mode_indicator)
    else $error("unit test start wrong");
  test_link_a: assert property (
    test_end_s |=> link_activity_indicator && mode_indicator && !st.run)
    else $error("link indicator not on after test");
  range_clear_a: assert property (
    (|channel_alert_flag_bits) && !(|a) |=> !(|channel_alert_flag_bits))
    else $error("flags not cleared in range");
endmodule : asf_alarm_status

// ===== dv/asf_apb_master.sv
// Purpose: remote reader model that reads and writes registers over apb
// Assumes: the slave may add any number of wait states
// Notes:   a request is held until pready is sampled high
`timescale 1ns/10ps
module asf_apb_master (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic [15:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    paddr   = 16'h0000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge clk);
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no cycle count assumed, the bench timeout ends a hang
    while (pready !== 1'b1) @(posedge clk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : asf_apb_master

// ===== dv/test_alarm_status_flag_logic.sv
// Purpose: checks alert flags, codes, history, interrupt and unit test
// Assumes: short unit test and flash counts for simulation
// Notes:   all register traffic goes through the remote reader model
`timescale 1ns/10ps
module test_alarm_status_flag_logic;
  localparam int TC = 20;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [15:0]      paddr;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             sample_valid = 1'b0;
  logic [3:0][15:0] pv = '0;
  logic [3:0][15:0] mv = {16'h1103, 16'h1102, 16'h1101, 16'h1100};
  logic [3:0][15:0] sv = {16'h2203, 16'h2202, 16'h2201, 16'h2200};
  logic [3:0]       flags;
  logic [3:0][15:0] defs;
  logic [15:0]      code;
  logic             alarm;
  logic             mode;
  logic             link;
  logic             irq;
  int               failures = 0;
  int               compares = 0;

  always #5 clk = ~clk;

  asf_apb_master asf_apb_master_inst (.clk(clk), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  asf_alarm_status #(.TEST_CYCLES(TC), .FLASH_CYCLES(4))
    asf_alarm_status_inst (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .process_value(pv),
    .manipulated_value(mv), .set_value(sv),
    .channel_alert_flag_bits(flags),
    .channel_alert_definition_words(defs),
    .latest_warning_code_word(code), .alarm_indicator(alarm),
    .mode_indicator(mode), .link_activity_indicator(link), .irq(irq));

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [11:0] idx, output logic [31:0] q);
    logic e;
    asf_apb_master_inst.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, q, e);
  endtask : rd

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    asf_apb_master_inst.xfer(1'b1, {2'b00, idx, 2'b00}, d, q, e);
    // the write lands at the access edge, so look one edge later
    @(posedge clk);
  endtask : wr

  // one measurement pulse, then let flags settle three cycles later
  task automatic smp(input int c, input logic [15:0] v);
    @(posedge clk);
    pv[c]        <= v;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : smp

  task automatic t_reset();
    logic [31:0] q;
    chk(flags, 0, "flags");
    chk(code, 0, "code");
    chk({alarm, mode, link, irq}, 4'b0100, "indicators");
    chk(pready, 1, "pready");
    rd(asf_pkg::IDX_IRQ_MASK, q);
    chk(q, 0, "mask");
  endtask : t_reset

  // pv 100..-100, rate 150..-150 on every channel
  task automatic t_limits();
    logic [3:0][15:0] lim = {16'hFF6A, 16'h0096, 16'hFF9C, 16'h0064};
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 4; k++)
        wr(12'h020 + 12'(c * 4 + k), {16'h0, lim[k]});
  endtask : t_limits

  task automatic t_alerts();
    logic [3:0][15:0] pre = {16'h0064, 16'hFF9C, 16'h0000, 16'h0000};
    logic [3:0][15:0] bad = {16'hFFC4, 16'h003C, 16'hFF9B, 16'h0065};
    logic [31:0]      q;
    for (int k = 0; k < 4; k++)
      for (int c = 0; c < 4; c++) begin
        smp(c, pre[k]);
        chk(flags, 0, "in range");
        smp(c, bad[k]);
        // flag, bit and code per alert kind
        chk(flags, 32'(1 << c), "flag");
        chk(defs[c], 32'(1 << (k + 2)), "def");
        chk(alarm, 1, "alarm");
        chk(code, (32'h0A0A + (k << 8)) | ((c + 1) << 4), "code");
        rd(asf_pkg::IDX_HIST0 + 12'h6, q);
        chk(q, 12'h004 + 12'(c), "hist addr");
        rd(asf_pkg::IDX_HIST0 + 12'h7, q);
        chk(q, bad[k], "hist pv");
        rd(asf_pkg::IDX_HIST0 + 12'h8, q);
        chk(q, mv[c], "hist mv");
        rd(asf_pkg::IDX_HIST0 + 12'h9, q);
        chk(q, sv[c], "hist sv");
        smp(c, 16'h0000);
        chk({flags, defs[c], alarm}, 0, "cleared");
        chk(code, 0, "code cleared");
      end
  endtask : t_alerts

  task automatic t_latest();
    logic [31:0] q;
    smp(0, 16'h0065);
    smp(1, 16'hFF9B);
    chk(code, 16'h0B2A, "newest");
    smp(1, 16'h0000);
    chk(code, 0, "source gone");
    chk(flags, 4'b0001, "other kept");
    @(posedge clk);
    pv[2] <= 16'h0065;
    pv[3] <= 16'h0065;
    smp(0, 16'h0000);
    chk(code, 16'h0A4A, "same cycle");
    chk(flags, 4'b1100, "two flags");
    rd(asf_pkg::IDX_FLAGS, q);
    chk(q, 32'hC, "flag word");
    rd(asf_pkg::IDX_WARN, q);
    chk(q, 32'h0A4A, "warn word");
    rd(asf_pkg::IDX_DEF0 + 12'h3, q);
    chk(q, 32'h4, "def word");
    pv[2] <= 16'h0000;
    smp(3, 16'h0000);
    chk(flags, 0, "all clear");
    chk(code, 0, "code gone");
  endtask : t_latest

  task automatic t_irq();
    logic [31:0] q;
    wr(asf_pkg::IDX_IRQ_STAT, 32'h1F);
    smp(2, 16'h0065);
    chk(irq, 0, "masked");
    rd(asf_pkg::IDX_IRQ_STAT, q);
    chk(q, 32'h4, "stat");
    wr(asf_pkg::IDX_IRQ_MASK, 32'h4);
    chk(irq, 1, "unmasked");
    wr(asf_pkg::IDX_IRQ_STAT, 32'h4);
    chk(irq, 0, "w1c");
    smp(2, 16'h0000);
  endtask : t_irq

  task automatic t_bad();
    logic [31:0] q;
    logic        e;
    asf_apb_master_inst.xfer(1'b0, 16'h00FC, 32'h0, q, e);
    chk(e, 1, "unmapped err");
    chk(q, 0, "unmapped data");
    asf_apb_master_inst.xfer(1'b1, 16'h0009, 32'h5, q, e);
    chk(e, 1, "misaligned");
  endtask : t_bad

  task automatic t_unit();
    logic [31:0] q;
    int          lows = 0;
    wr(asf_pkg::IDX_CTRL, 32'h1);
    repeat (TC - 4) begin
      @(posedge clk);
      lows += (mode === 1'b0) ? 1 : 0;
    end
    chk(link, 0, "link in test");
    chk(lows > 0, 1, "mode flash");
    repeat (10) @(posedge clk);
    chk({link, mode}, 2'b11, "test done");
    rd(asf_pkg::IDX_IRQ_STAT, q);
    chk(q[4], 1, "done event");
    rd(asf_pkg::IDX_CTRL, q);
    chk(q, 32'h4, "ctrl done");
  endtask : t_unit

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_limits();
    t_alerts();
    t_latest();
    t_irq();
    t_bad();
    t_unit();
    conclude();
  end

  // whole sequence needs well under 20 us
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule : test_alarm_status_flag_logic
